// ### hw/swps_consts.svh
`ifndef SWPS_CONSTS_SVH
`define SWPS_CONSTS_SVH

// ==========================================================
// Bus widths
`define SWPS_ADDR_W 8
`define SWPS_DATA_W 32
`define SWPS_TIME_W 24

// ==========================================================
// Register byte offsets
`define SWPS_OFS_CTRL 8'h00
`define SWPS_OFS_CLOSE_TIME 8'h04
`define SWPS_OFS_OPEN_TIME 8'h08
`define SWPS_OFS_STATUS 8'h0c
`define SWPS_OFS_IRQ_STAT 8'h10
`define SWPS_OFS_IRQ_MASK 8'h14
`define SWPS_OFS_CMD 8'h18

// ==========================================================
// Field positions
`define SWPS_CTRL_CWIRE 0
`define SWPS_CTRL_OWIRE 1
`define SWPS_CMD_CLOSE 0
`define SWPS_CMD_OPEN 1
`define SWPS_EV_OK 0
`define SWPS_EV_FAIL 1
`define SWPS_EV_CHG 2
`define SWPS_EV_W 3

// ==========================================================
// Reset values, travel times in clock cycles
`define SWPS_CTRL_RST 2'h3
`define SWPS_CLOSE_TIME_RST 24'h0003e8
`define SWPS_OPEN_TIME_RST 24'h0003e8
`define SWPS_MASK_RST 3'h0

`endif

// ### hw/swps_pkg.sv
package swps_pkg;

  typedef enum logic [1:0] {
    SWPS_POS_MID = 2'h0,
    SWPS_POS_OPEN = 2'h1,
    SWPS_POS_CLOSED = 2'h2,
    SWPS_POS_FAULT = 2'h3
  } swps_pos_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CLOSING = 5'h02,
    ST_OPENING = 5'h04,
    ST_DONE = 5'h08,
    ST_FAIL = 5'h10
  } swps_state_e;

endpackage

// ### hw/swps_sync.sv
`timescale 1ns/1ns
module swps_sync
  import swps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic d_in,
  output logic q_out
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

// ### hw/swps_timer.sv
`timescale 1ns/1ns
`include "swps_consts.svh"
module swps_timer
  import swps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [`SWPS_TIME_W-1:0] load_in,
  output logic busy_out,
  output logic expired_out
);

  logic [`SWPS_TIME_W-1:0] cnt_q;
  logic [`SWPS_TIME_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;

  // A zero load still runs one cycle
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    expired_out = 1'b0;
    if (start_in)
    begin
      cnt_d = (load_in == '0) ? `SWPS_TIME_W'(1) : load_in;
      busy_d = 1'b1;
    end
    else if (stop_in)
      busy_d = 1'b0;
    else if (busy_q)
    begin
      if (cnt_q == `SWPS_TIME_W'(1))
      begin
        busy_d = 1'b0;
        expired_out = 1'b1;
      end
      else
        cnt_d = cnt_q - `SWPS_TIME_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy_out = busy_q;

endmodule

// ### hw/swps_top.sv
// Behaviour
// - Both contacts synchronised every cycle; position from levels plus travel timers.
// - Close command starts close timer; in transit while it runs unconfirmed.
// - Closed feedback in time gives closed flag; timer expiry first gives faulted.
// - Open command starts open timer; open flag in time, faulted on expiry.
// - Position code: 0 intermediate, 1 open, 2 closed, 3 faulted.
// - Both wired, equal levels while timing: code 0, in transit only.
// - Both wired, equal levels with no timer running: code 3, faulted only.
// - Exactly one contact configured raises the single contact flag.
// - Single contact supervises only its own direction of command.
// - Closed-only: close starts timer; feedback in time gives closed and success.
// - Travel time elapsed before end position: faulted set, in transit dropped.
// - Closed-only: low is 0 while timing else 1; high is 2.
// - No contact configured forces position code 3.
// - Open-only: open command timed; feedback gives open and success, expiry faulted.
`timescale 1ns/1ns
`include "swps_consts.svh"
module swps_top
  import swps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic aux_closed_in,
  input wire logic aux_open_in,
  input wire logic close_cmd_in,
  input wire logic open_cmd_in,
  input wire logic [`SWPS_ADDR_W-1:0] addr_in,
  input wire logic [`SWPS_DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`SWPS_DATA_W-1:0] rd_data_out,
  output logic pos_closed_out,
  output logic pos_open_out,
  output logic in_transit_out,
  output logic faulted_out,
  output logic [1:0] pos_code_out,
  output logic single_contact_flag_out,
  output logic command_success_flag_out,
  output logic irq_out
);

  // ==========================================================
  // Contact synchronisers
  logic [1:0] aux_raw;
  logic [1:0] aux_s;
  logic c_s;
  logic o_s;

  assign aux_raw = {aux_open_in, aux_closed_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      swps_sync u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .d_in(aux_raw[gi]),
        .q_out(aux_s[gi])
      );
    end
  endgenerate

  assign c_s = aux_s[0];
  assign o_s = aux_s[1];

  // ==========================================================
  // Position decode
  function automatic swps_pos_e pos_decode(input logic [1:0] wired, input logic c,
    input logic o, input logic run_c, input logic run_o, input logic fail);
    swps_pos_e p;
    p = SWPS_POS_FAULT;
    case (wired)
      2'h3:
      begin
        if (c != o)
          p = c ? SWPS_POS_CLOSED : SWPS_POS_OPEN;
        else if (run_c || run_o)
          p = SWPS_POS_MID;
        else
          p = SWPS_POS_FAULT;
      end
      2'h1:
      begin
        if (c)
          p = SWPS_POS_CLOSED;
        else if (run_c)
          p = SWPS_POS_MID;
        else
          p = SWPS_POS_OPEN;
      end
      2'h2:
      begin
        if (o)
          p = SWPS_POS_OPEN;
        else if (run_o)
          p = SWPS_POS_MID;
        else
          p = SWPS_POS_CLOSED;
      end
      default: p = SWPS_POS_FAULT;
    endcase
    if (fail)
      p = SWPS_POS_FAULT;
    return p;
  endfunction

  // ==========================================================
  // Registers written by software
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [`SWPS_TIME_W-1:0] close_time_q;
  logic [`SWPS_TIME_W-1:0] close_time_d;
  logic [`SWPS_TIME_W-1:0] open_time_q;
  logic [`SWPS_TIME_W-1:0] open_time_d;
  logic [`SWPS_EV_W-1:0] irq_mask_q;
  logic [`SWPS_EV_W-1:0] irq_mask_d;
  logic sw_close;
  logic sw_open;

  always_comb
  begin
    ctrl_d = ctrl_q;
    close_time_d = close_time_q;
    open_time_d = open_time_q;
    irq_mask_d = irq_mask_q;
    sw_close = 1'b0;
    sw_open = 1'b0;
    if (wr_in)
    begin
      case (addr_in)
        `SWPS_OFS_CTRL: ctrl_d = wr_data_in[1:0];
        `SWPS_OFS_CLOSE_TIME: close_time_d = wr_data_in[`SWPS_TIME_W-1:0];
        `SWPS_OFS_OPEN_TIME: open_time_d = wr_data_in[`SWPS_TIME_W-1:0];
        `SWPS_OFS_IRQ_MASK: irq_mask_d = wr_data_in[`SWPS_EV_W-1:0];
        `SWPS_OFS_CMD:
        begin
          sw_close = wr_data_in[`SWPS_CMD_CLOSE];
          sw_open = wr_data_in[`SWPS_CMD_OPEN];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_q <= `SWPS_CTRL_RST;
      close_time_q <= `SWPS_CLOSE_TIME_RST;
      open_time_q <= `SWPS_OPEN_TIME_RST;
      irq_mask_q <= `SWPS_MASK_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      close_time_q <= close_time_d;
      open_time_q <= open_time_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ==========================================================
  // Travel supervision
  swps_state_e state_q;
  swps_state_e state_d;
  logic go_close;
  logic go_open;
  logic both_wired;
  logic close_ok;
  logic open_ok;
  logic tmr_start;
  logic tmr_stop;
  logic [`SWPS_TIME_W-1:0] tmr_load;
  logic tmr_busy;
  logic tmr_expired;

  assign go_close = close_cmd_in | sw_close;
  assign go_open = open_cmd_in | sw_open;
  assign both_wired = ctrl_q[`SWPS_CTRL_CWIRE] & ctrl_q[`SWPS_CTRL_OWIRE];
  assign close_ok = both_wired ? (c_s & ~o_s) : c_s;
  assign open_ok = both_wired ? (o_s & ~c_s) : o_s;

  // Open wins when both commands coincide
  always_comb
  begin
    state_d = state_q;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    tmr_load = close_time_q;
    if (go_open)
    begin
      if (ctrl_q[`SWPS_CTRL_OWIRE])
      begin
        state_d = ST_OPENING;
        tmr_start = 1'b1;
        tmr_load = open_time_q;
      end
      else
      begin
        state_d = ST_IDLE;
        tmr_stop = 1'b1;
      end
    end
    else if (go_close)
    begin
      if (ctrl_q[`SWPS_CTRL_CWIRE])
      begin
        state_d = ST_CLOSING;
        tmr_start = 1'b1;
      end
      else
      begin
        state_d = ST_IDLE;
        tmr_stop = 1'b1;
      end
    end
    else
    begin
      case (state_q)
        ST_CLOSING:
        begin
          if (close_ok)
          begin
            state_d = ST_DONE;
            tmr_stop = 1'b1;
          end
          else if (tmr_expired)
            state_d = ST_FAIL;
        end
        ST_OPENING:
        begin
          if (open_ok)
          begin
            state_d = ST_DONE;
            tmr_stop = 1'b1;
          end
          else if (tmr_expired)
            state_d = ST_FAIL;
        end
        ST_IDLE, ST_DONE, ST_FAIL: ;
        default:
        begin
          state_d = ST_IDLE;
          tmr_stop = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  swps_timer u_timer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(tmr_start),
    .stop_in(tmr_stop),
    .load_in(tmr_load),
    .busy_out(tmr_busy),
    .expired_out(tmr_expired)
  );

  // ==========================================================
  // Outputs, interrupt status and read port
  swps_pos_e code_d;
  swps_pos_e code_q;
  logic success_q;
  logic single_q;
  logic [`SWPS_EV_W-1:0] ev;
  logic [`SWPS_EV_W-1:0] irq_stat_q;
  logic [`SWPS_EV_W-1:0] irq_stat_d;
  logic irq_q;
  logic irq_d;
  logic [`SWPS_DATA_W-1:0] rd_data_q;
  logic [`SWPS_DATA_W-1:0] rd_data_d;
  logic stat_clr;

  always_comb
  begin
    code_d = pos_decode(ctrl_q, c_s, o_s, state_q == ST_CLOSING,
      state_q == ST_OPENING, state_q == ST_FAIL);
    ev = '0;
    ev[`SWPS_EV_OK] = (state_d == ST_DONE) && (state_q != ST_DONE);
    ev[`SWPS_EV_FAIL] = (state_d == ST_FAIL) && (state_q != ST_FAIL);
    ev[`SWPS_EV_CHG] = code_d != code_q;
    stat_clr = rd_in && (addr_in == `SWPS_OFS_IRQ_STAT);
    // A new event beats the clear of the same read
    irq_stat_d = (irq_stat_q & ~{`SWPS_EV_W{stat_clr}}) | ev;
    irq_d = |(irq_stat_d & irq_mask_d);
    rd_data_d = '0;
    if (rd_in)
    begin
      case (addr_in)
        `SWPS_OFS_CTRL: rd_data_d[1:0] = ctrl_q;
        `SWPS_OFS_CLOSE_TIME: rd_data_d[`SWPS_TIME_W-1:0] = close_time_q;
        `SWPS_OFS_OPEN_TIME: rd_data_d[`SWPS_TIME_W-1:0] = open_time_q;
        `SWPS_OFS_STATUS: rd_data_d[7:0] = {success_q, single_q, code_q == SWPS_POS_FAULT,
          code_q == SWPS_POS_MID, code_q == SWPS_POS_OPEN, code_q == SWPS_POS_CLOSED,
          code_q};
        `SWPS_OFS_IRQ_STAT: rd_data_d[`SWPS_EV_W-1:0] = irq_stat_q;
        `SWPS_OFS_IRQ_MASK: rd_data_d[`SWPS_EV_W-1:0] = irq_mask_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      code_q <= SWPS_POS_FAULT;
      success_q <= 1'b0;
      single_q <= 1'b0;
      irq_stat_q <= '0;
      irq_q <= 1'b0;
      rd_data_q <= '0;
    end
    else
    begin
      code_q <= code_d;
      success_q <= state_q == ST_DONE;
      single_q <= ctrl_q[`SWPS_CTRL_CWIRE] ^ ctrl_q[`SWPS_CTRL_OWIRE];
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign pos_code_out = code_q;
  assign pos_closed_out = code_q == SWPS_POS_CLOSED;
  assign pos_open_out = code_q == SWPS_POS_OPEN;
  assign in_transit_out = code_q == SWPS_POS_MID;
  assign faulted_out = code_q == SWPS_POS_FAULT;
  assign single_contact_flag_out = single_q;
  assign command_success_flag_out = success_q;
  assign irq_out = irq_q;
  assign rd_data_out = rd_data_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_close_start: assert property (
    go_close && !go_open && ctrl_q[`SWPS_CTRL_CWIRE] |=> state_q == ST_CLOSING && tmr_busy)
    else $error("close command did not start travel timer");

  a_closed_in_time: assert property (
    state_q == ST_CLOSING && close_ok && !go_open && !go_close |=> ##1
    pos_closed_out && command_success_flag_out && !in_transit_out)
    else $error("closed feedback in time not reported");

  a_open_start: assert property (
    go_open && ctrl_q[`SWPS_CTRL_OWIRE] |=> state_q == ST_OPENING && tmr_busy)
    else $error("open command did not start travel timer");

  a_code_flags: assert property (
    faulted_out == (pos_code_out == 2'h3) && in_transit_out == (pos_code_out == 2'h0))
    else $error("flags disagree with position code");

  a_equal_timing: assert property (
    both_wired && c_s == o_s && tmr_busy && state_q != ST_FAIL |=>
    pos_code_out == 2'h0 && in_transit_out && !faulted_out && !pos_closed_out)
    else $error("equal levels while timing not intermediate");

  a_open_pattern: assert property (
    both_wired && !c_s && o_s && state_q != ST_FAIL |=> pos_open_out && pos_code_out == 2'h1)
    else $error("open pattern not decoded");

  a_equal_idle: assert property (
    both_wired && c_s == o_s && !tmr_busy |=> faulted_out && !in_transit_out)
    else $error("equal levels without timer not faulted");

  a_single_flag: assert property (
    $changed(ctrl_q) |=> single_contact_flag_out == (ctrl_q == 2'h1 || ctrl_q == 2'h2))
    else $error("single contact flag wrong");

  a_dir_only: assert property (
    ctrl_q == 2'h1 && go_open |=> state_q == ST_IDLE && !tmr_busy)
    else $error("unsupervised direction was timed");

  a_expire_fault: assert property (
    tmr_expired && !go_open && !go_close |=> ##1 faulted_out && !in_transit_out)
    else $error("travel expiry not reported as fault");

  a_closed_only: assert property (
    ctrl_q == 2'h1 && !c_s && state_q == ST_IDLE |=> pos_code_out == 2'h1)
    else $error("closed-only low input idle not open");

  a_no_contact: assert property (
    ctrl_q == 2'h0 |=> pos_code_out == 2'h3)
    else $error("no contact configured not faulted");

  a_new_cmd_clear: assert property (
    tmr_start |=> ##1 !command_success_flag_out)
    else $error("new command kept old success");

  c_close_ok: cover property (state_q == ST_CLOSING ##1 state_q == ST_DONE);
  c_open_fail: cover property (state_q == ST_OPENING ##1 state_q == ST_FAIL);
  c_single_mid: cover property (single_q && in_transit_out);
  c_irq: cover property (!irq_out ##1 irq_out);

endmodule

// ### verif/swps_aux_model.sv
`timescale 1ns/1ns
// ==========================================
// Breaker auxiliary contacts: leave the end position at once on a command,
// reach the new one after delay_in + 1 cycles unless stuck_in holds them midway
module swps_aux_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic close_in,
  input wire logic open_in,
  input wire logic stuck_in,
  input wire logic mid_high_in,
  input wire logic [7:0] delay_in,
  output logic aux_closed_out,
  output logic aux_open_out
);
  logic [7:0] cnt_q;
  logic moving_q;
  logic dir_open_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_q <= 8'h00;
      moving_q <= 1'b0;
      dir_open_q <= 1'b1;
    end
    else if (open_in || close_in)
    begin
      cnt_q <= delay_in;
      moving_q <= 1'b1;
      dir_open_q <= open_in;
    end
    else if (moving_q && !stuck_in && cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
    else if (moving_q && !stuck_in)
      moving_q <= 1'b0;
  end

  // Midway both contacts show the same level, low or high as commanded
  assign aux_closed_out = moving_q ? mid_high_in : !dir_open_q;
  assign aux_open_out = moving_q ? mid_high_in : dir_open_q;
endmodule

// ### verif/switchgear_position_supervisor_bench.sv
`timescale 1ns/1ns
`include "swps_consts.svh"
module switchgear_position_supervisor_bench;
  import swps_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic close_cmd = 1'b0;
  logic open_cmd = 1'b0;
  logic m_close = 1'b0;
  logic m_open = 1'b0;
  logic stuck = 1'b0;
  logic mid_high = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] delay = 8'h08;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, v;
  logic aux_c, aux_o, p_c, p_o, p_t, p_f, single, succ, irq;
  logic [1:0] code;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_trav, d_move;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1c};
  logic [31:0] rv [5] = '{32'h3, 32'h3e8, 32'h3e8, 32'h0, 32'h0};

  always #5 clk_in = ~clk_in;

  swps_aux_model model_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .close_in(m_close),
    .open_in(m_open), .stuck_in(stuck), .mid_high_in(mid_high), .delay_in(delay),
    .aux_closed_out(aux_c), .aux_open_out(aux_o));

  swps_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .aux_closed_in(aux_c),
    .aux_open_in(aux_o), .close_cmd_in(close_cmd), .open_cmd_in(open_cmd),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
    .pos_closed_out(p_c), .pos_open_out(p_o), .in_transit_out(p_t), .faulted_out(p_f),
    .pos_code_out(code), .single_contact_flag_out(single),
    .command_success_flag_out(succ), .irq_out(irq));

  // ==========================================
  // Checks and bus cycles
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] stat_word(input logic [1:0] c, input logic sg, input logic s);
    return {s, sg, c == 2'h3, c == 2'h0, c == 2'h1, c == 2'h2, c};
  endfunction

  task automatic chk_pos(input logic [1:0] c, input logic s);
    chk("position flags", 32'({s, c == 2'h2, c == 2'h1, c == 2'h0, c == 2'h3, c}),
      32'({succ, p_c, p_o, p_t, p_f, code}));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cmd(input logic o, input logic via_reg);
    @(posedge clk_in);
    if (via_reg)
    begin
      addr <= `SWPS_OFS_CMD;
      wdata <= {30'h0, o, ~o};
      wr <= 1'b1;
    end
    else if (o)
      open_cmd <= 1'b1;
    else
      close_cmd <= 1'b1;
    m_open <= o;
    m_close <= ~o;
    @(posedge clk_in);
    wr <= 1'b0;
    open_cmd <= 1'b0;
    close_cmd <= 1'b0;
    m_open <= 1'b0;
    m_close <= 1'b0;
  endtask

  // One move: check midway, then the end result after travel or expiry
  task automatic move(input logic o, input logic st, input logic mh, input logic via_reg,
    input logic [1:0] mid_c, input logic [1:0] end_c, input logic s);
    stuck <= st;
    mid_high <= mh;
    d_move = 8 + ($urandom % 10);
    delay <= 8'(d_move);
    cmd(o, via_reg);
    tick(6);
    chk_pos(mid_c, 1'b0);
    if (st)
      tick(t_trav + 4);
    else
      tick(d_move + 8);
    chk_pos(end_c, s);
    $display("move done dir=%0d stuck=%0d", o, st);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========================================
  // Main sequence
  initial
  begin
    logic o, st;
    void'($urandom(32'h8df9));
    t_trav = 40 + ($urandom % 20);
    tick(10);
    chk_pos(2'h3, 1'b0);
    rst_b_in <= 1'b1;
    tick(5);
    chk_pos(2'h1, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(ra[i], v);
      chk("reset register", rv[i], v);
    end
    reg_wr(`SWPS_OFS_CLOSE_TIME, 32'(t_trav));
    reg_wr(`SWPS_OFS_OPEN_TIME, 32'(t_trav));
    reg_rd(`SWPS_OFS_OPEN_TIME, v);
    chk("open time", 32'(t_trav), v);
    $display("registers done");
    reg_rd(`SWPS_OFS_IRQ_STAT, v);
    reg_wr(`SWPS_OFS_IRQ_MASK, 32'h1);
    move(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2, 1'b1);
    chk("irq raised", 1, irq);
    reg_rd(`SWPS_OFS_STATUS, v);
    chk("status", 32'(stat_word(2'h2, 1'b0, 1'b1)), v);
    reg_rd(`SWPS_OFS_IRQ_STAT, v);
    chk("irq success bit", 1, v & 32'h1);
    tick(2);
    chk("irq cleared", 0, irq);
    move(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 2'h1, 1'b1);
    reg_wr(`SWPS_OFS_IRQ_MASK, 32'h0);
    reg_rd(`SWPS_OFS_IRQ_STAT, v);
    move(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 2'h3, 1'b0);
    chk("irq masked", 0, irq);
    move(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 1'b1);
    // Directions alternate: every command is first checked midway at code 0, then at its end result
    for (int i = 0; i < 4; i++)
    begin
      o = i[0];
      st = 1'($urandom);
      move(o, st, 1'($urandom), 1'($urandom), 2'h0, st ? 2'h3 : (o ? 2'h1 : 2'h2), !st);
    end
    move(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2, 1'b1);
    move(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 1'b1);
    reg_wr(`SWPS_OFS_CTRL, 32'h1);
    tick(4);
    chk("single flag", 1, single);
    move(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2, 1'b1);
    move(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 2'h1, 1'b0);
    reg_wr(`SWPS_OFS_CTRL, 32'h2);
    move(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h2, 1'b0);
    move(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'h3, 1'b0);
    move(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 1'b1);
    reg_wr(`SWPS_OFS_CTRL, 32'h0);
    tick(4);
    chk("no contact code", 3, code);
    chk("no contact single", 0, single);
    test_done();
  end
endmodule
